// >>> rtl/timer8_pkg.sv
// Package with constants, register map and types for the 8-bit timer compare block.
package timer8_pkg;

  // ==========================================================================
  // Register map (byte addresses on APB, one word each)
  // ==========================================================================
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_MATCH_A = 8'h04;
  localparam logic [7:0] ADDR_MATCH_B = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
  localparam logic [7:0] ADDR_PORT = 8'h18;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int CTRL_WAVE_LSB = 0;
  localparam int CTRL_SRC_LSB = 3;
  localparam int CTRL_ACT_A_LSB = 6;
  localparam int CTRL_ACT_B_LSB = 8;
  localparam int CTRL_FORCE_A = 10;
  localparam int CTRL_FORCE_B = 11;

  // Flag register and irq enable bit positions.
  localparam int FLAG_WRAP = 0;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_MATCH_B = 2;

  // Port register fields: value bits 1:0, direction bits 3:2.
  localparam int PORT_DIR_LSB = 2;

  // ==========================================================================
  // Values after reset and fixed values
  // ==========================================================================
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] MATCH_RESET = 8'h00;
  localparam logic WAVE_OUT_RESET = 1'b0;

  // Waveform mode codes; codes other than these four are treated as PWM.
  typedef enum logic [2:0] {
    WAVE_NORMAL = 3'h0,
    WAVE_PC_PWM = 3'h1,
    WAVE_CLEAR_ON_MATCH = 3'h2,
    WAVE_FAST_PWM = 3'h3
  } wave_mode_t;

  // Output action codes in non-PWM modes.
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_SET = 2'h3
  } out_action_t;

  // Per-channel pin group.
  typedef struct packed {
    logic pin_out;
    logic pin_oe_n;
  } pin_drive_t;

endpackage : timer8_pkg

// >>> rtl/timer8_compare_output_unit.sv
// Output compare unit of an 8-bit timer with Normal and clear-on-match counting.
//
// Notes on behaviour
// - Compare count against both values continuously.
// - Match flag sets on the following tick.
// - Enabled flag raises irq; serviced/write-one clears.
// - PWM buffers compare values; non-PWM bypasses.
// - CPU reaches buffer or active copy.
// - Force strobe acts like match, no flag.
// - Counter write blocks matches next tick.
// - Output state survives mode changes.
// - Action bits unbuffered, govern next match.
// - Reset clears output states to zero.
// - Nonzero action overrides port value; direction kept.
// - Action zero leaves output state unchanged.
// - Normal mode counts up, wraps 0xff.
// - Normal: wrap flag sets when count zero.
// - Normal: counter writable any time.
// - Clear-on-match: clear count at channel A.
// - Clear-on-match: flag A each period.
// - Value below count waits for wrap.
// - Toggle action inverts output each match.
// - Clear-on-match: wrap flag on max-to-zero.
// - Tick is one-cycle enable gating count, matches and flag sets.
// - CPU counter write beats count/clear.
// - Source select zero stops the timer.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps

module timer8_compare_output_unit
  import timer8_pkg::*;
#(
  parameter int COUNT_W = 8
) (
  input wire logic clock_i,             // I/O clock
  input wire logic rst_i,               // Asynchronous reset, active high
  input wire logic psel_i,              // APB select
  input wire logic penable_i,           // APB enable
  input wire logic pwrite_i,            // APB direction
  input wire logic [7:0] paddr_i,       // APB byte address
  input wire logic [31:0] pwdata_i,     // APB write data
  output logic [31:0] prdata_o,         // APB read data
  output logic pready_o,                // APB ready
  output logic pslverr_o,               // APB error on unmapped address
  input wire logic prescale_tick_i,     // Enable pulse from prescaler
  input wire logic irq_ack_wrap_i,      // Wrap interrupt serviced
  input wire logic irq_ack_a_i,         // Channel A interrupt serviced
  input wire logic irq_ack_b_i,         // Channel B interrupt serviced
  output logic irq_wrap_o,              // Wrap interrupt request
  output logic irq_match_a_o,           // Channel A interrupt request
  output logic irq_match_b_o,           // Channel B interrupt request
  output pin_drive_t wave_pin_a_o,      // Pin A value and enable
  output pin_drive_t wave_pin_b_o,      // Pin B value and enable
  output logic wave_out_a_o,            // Internal output state A
  output logic wave_out_b_o             // Internal output state B
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [COUNT_W-1:0] tick_count_reg;
  logic [COUNT_W-1:0] match_value_a_reg;
  logic [COUNT_W-1:0] match_value_b_reg;
  logic [COUNT_W-1:0] match_buf_a_reg;
  logic [COUNT_W-1:0] match_buf_b_reg;
  logic [2:0] wave_mode_sel_reg;
  logic [2:0] tick_source_sel_reg;
  logic [1:0] out_action_bits_a_reg;
  logic [1:0] out_action_bits_b_reg;
  logic [2:0] timer_irq_flags_reg;
  logic [2:0] timer_irq_enable_reg;
  logic [1:0] port_value_reg;
  logic [1:0] wave_pin_direction_reg;
  logic wave_out_a_reg;
  logic wave_out_b_reg;
  logic block_reg;
  logic match_a_pend_reg;
  logic match_b_pend_reg;

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  wire wr = psel_i && penable_i && pwrite_i;
  wire sel_count = (paddr_i == ADDR_COUNT);
  wire sel_ma = (paddr_i == ADDR_MATCH_A);
  wire sel_mb = (paddr_i == ADDR_MATCH_B);
  wire sel_ctrl = (paddr_i == ADDR_CTRL);
  wire sel_flags = (paddr_i == ADDR_FLAGS);
  wire sel_irq_en = (paddr_i == ADDR_IRQ_EN);
  wire sel_port = (paddr_i == ADDR_PORT);
  wire mapped = sel_count | sel_ma | sel_mb | sel_ctrl | sel_flags | sel_irq_en | sel_port;
  wire wr_count = wr && sel_count;
  wire wr_ma = wr && sel_ma;
  wire wr_mb = wr && sel_mb;
  wire wr_ctrl = wr && sel_ctrl;
  wire wr_flags = wr && sel_flags;
  wire wr_irq_en = wr && sel_irq_en;
  wire wr_port = wr && sel_port;

  // ==========================================================================
  // Mode and tick
  // ==========================================================================
  wire is_normal = (wave_mode_sel_reg == WAVE_NORMAL);
  wire is_clr = (wave_mode_sel_reg == WAVE_CLEAR_ON_MATCH);
  wire is_pwm = !(is_normal || is_clr);
  wire is_pc_pwm = wave_mode_sel_reg[1:0] == 2'h1;
  wire top_is_a = wave_mode_sel_reg[2] || is_clr;
  wire timer_tick = prescale_tick_i && (tick_source_sel_reg != 3'h0);

  // ==========================================================================
  // Comparator and counter next state
  // ==========================================================================
  wire eq_a = (tick_count_reg == match_value_a_reg);
  wire eq_b = (tick_count_reg == match_value_b_reg);
  wire match_a = eq_a && !block_reg;
  wire match_b = eq_b && !block_reg;
  wire [COUNT_W-1:0] top_val = top_is_a ? match_value_a_reg : COUNT_MAX[COUNT_W-1:0];
  wire at_top = (tick_count_reg == top_val);
  wire count_inc_wrap = (tick_count_reg == COUNT_MAX[COUNT_W-1:0]);
  // A blocked match does not clear either; a value under the count waits for wrap.
  wire clr_now = is_clr && match_a;
  // Phase-correct direction drives the down count and the buffer update at top.
  logic dn_reg;
  wire [COUNT_W-1:0] count_step = dn_reg ? tick_count_reg - 1'b1 : tick_count_reg + 1'b1;
  wire [COUNT_W-1:0] count_next = wr_count ? pwdata_i[COUNT_W-1:0] :
    (!timer_tick ? tick_count_reg :
     (clr_now || (!is_pc_pwm && is_pwm && at_top)) ? COUNT_BOTTOM[COUNT_W-1:0] :
     count_step);
  // Overflow only on max-to-zero; in clear-on-match a clear below max is no wrap.
  wire wrap_evt = timer_tick && !wr_count && !is_pwm && count_inc_wrap;
  wire buf_load = timer_tick && is_pwm &&
    (is_pc_pwm ? (at_top && !dn_reg) : (tick_count_reg == top_val));

  // ==========================================================================
  // Output action
  // ==========================================================================
  function automatic logic act(input logic [1:0] bits, input logic cur);
    unique case (bits)
      ACT_NONE: act = cur;
      ACT_TOGGLE: act = ~cur;
      ACT_CLEAR: act = 1'b0;
      ACT_SET: act = 1'b1;
    endcase
  endfunction : act

  wire force_a = wr_ctrl && pwdata_i[CTRL_FORCE_A] && !is_pwm;
  wire force_b = wr_ctrl && pwdata_i[CTRL_FORCE_B] && !is_pwm;
  // Action bits are read live, so a new setting governs the next match.
  wire fire_a = force_a || (timer_tick && match_a && !is_pwm);
  wire fire_b = force_b || (timer_tick && match_b && !is_pwm);
  wire wave_a_next = fire_a ? act(out_action_bits_a_reg, wave_out_a_reg) : wave_out_a_reg;
  wire wave_b_next = fire_b ? act(out_action_bits_b_reg, wave_out_b_reg) : wave_out_b_reg;

  // Flags: hardware set wins over software or service clear.
  wire [2:0] flag_set = {timer_tick && match_b_pend_reg,
                         timer_tick && match_a_pend_reg,
                         wrap_evt || (timer_tick && is_pwm &&
                           (is_pc_pwm ? tick_count_reg == COUNT_BOTTOM[COUNT_W-1:0] : at_top))};
  wire [2:0] flag_clr = ({3{wr_flags}} & pwdata_i[2:0]) |
                        {irq_ack_b_i, irq_ack_a_i, irq_ack_wrap_i};
  wire [2:0] flags_next = (timer_irq_flags_reg & ~flag_clr) | flag_set;

  // ==========================================================================
  // Clocked state
  // ==========================================================================
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tick_count_reg <= COUNT_RESET[COUNT_W-1:0];
      dn_reg <= 1'b0;
      block_reg <= 1'b0;
      match_a_pend_reg <= 1'b0;
      match_b_pend_reg <= 1'b0;
      timer_irq_flags_reg <= 3'h0;
    end else begin
      tick_count_reg <= count_next;
      if (wr_count) begin
        block_reg <= 1'b1;
      end else if (timer_tick) begin
        block_reg <= 1'b0;
      end
      if (!is_pc_pwm) begin
        dn_reg <= 1'b0;
      end else if (timer_tick && at_top) begin
        dn_reg <= 1'b1;
      end else if (timer_tick && tick_count_reg == COUNT_BOTTOM[COUNT_W-1:0]) begin
        dn_reg <= 1'b0;
      end
      if (timer_tick) begin
        match_a_pend_reg <= match_a;
        match_b_pend_reg <= match_b;
      end
      timer_irq_flags_reg <= flags_next;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      match_value_a_reg <= MATCH_RESET[COUNT_W-1:0];
      match_value_b_reg <= MATCH_RESET[COUNT_W-1:0];
      match_buf_a_reg <= MATCH_RESET[COUNT_W-1:0];
      match_buf_b_reg <= MATCH_RESET[COUNT_W-1:0];
    end else begin
      if (wr_ma) begin
        match_buf_a_reg <= pwdata_i[COUNT_W-1:0];
      end
      if (wr_mb) begin
        match_buf_b_reg <= pwdata_i[COUNT_W-1:0];
      end
      if (!is_pwm && wr_ma) begin
        match_value_a_reg <= pwdata_i[COUNT_W-1:0];
      end else if (buf_load) begin
        match_value_a_reg <= match_buf_a_reg;
      end
      if (!is_pwm && wr_mb) begin
        match_value_b_reg <= pwdata_i[COUNT_W-1:0];
      end else if (buf_load) begin
        match_value_b_reg <= match_buf_b_reg;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wave_mode_sel_reg <= 3'h0;
      tick_source_sel_reg <= 3'h0;
      out_action_bits_a_reg <= 2'h0;
      out_action_bits_b_reg <= 2'h0;
      timer_irq_enable_reg <= 3'h0;
      port_value_reg <= 2'h0;
      wave_pin_direction_reg <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        wave_mode_sel_reg <= pwdata_i[CTRL_WAVE_LSB +: 3];
        tick_source_sel_reg <= pwdata_i[CTRL_SRC_LSB +: 3];
        out_action_bits_a_reg <= pwdata_i[CTRL_ACT_A_LSB +: 2];
        out_action_bits_b_reg <= pwdata_i[CTRL_ACT_B_LSB +: 2];
      end
      if (wr_irq_en) begin
        timer_irq_enable_reg <= pwdata_i[2:0];
      end
      if (wr_port) begin
        port_value_reg <= pwdata_i[1:0];
        wave_pin_direction_reg <= pwdata_i[PORT_DIR_LSB +: 2];
      end
    end
  end

  // Output states are not touched by mode writes, so they persist.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wave_out_a_reg <= WAVE_OUT_RESET;
      wave_out_b_reg <= WAVE_OUT_RESET;
    end else begin
      wave_out_a_reg <= wave_a_next;
      wave_out_b_reg <= wave_b_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    if (sel_count) rdata[COUNT_W-1:0] = tick_count_reg;
    if (sel_ma) rdata[COUNT_W-1:0] = is_pwm ? match_buf_a_reg : match_value_a_reg;
    if (sel_mb) rdata[COUNT_W-1:0] = is_pwm ? match_buf_b_reg : match_value_b_reg;
    if (sel_ctrl) rdata[9:0] = {out_action_bits_b_reg, out_action_bits_a_reg,
                                tick_source_sel_reg, wave_mode_sel_reg};
    if (sel_flags) rdata[2:0] = timer_irq_flags_reg;
    if (sel_irq_en) rdata[2:0] = timer_irq_enable_reg;
    if (sel_port) rdata[3:0] = {wave_pin_direction_reg, port_value_reg};
  end

  assign prdata_o = rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign irq_wrap_o = timer_irq_flags_reg[FLAG_WRAP] && timer_irq_enable_reg[FLAG_WRAP];
  assign irq_match_a_o = timer_irq_flags_reg[FLAG_MATCH_A] && timer_irq_enable_reg[FLAG_MATCH_A];
  assign irq_match_b_o = timer_irq_flags_reg[FLAG_MATCH_B] && timer_irq_enable_reg[FLAG_MATCH_B];
  // Override follows the action bits only; direction stays with the port.
  assign wave_pin_a_o.pin_out = (out_action_bits_a_reg != 2'h0) ? wave_out_a_reg
                                                                 : port_value_reg[0];
  assign wave_pin_b_o.pin_out = (out_action_bits_b_reg != 2'h0) ? wave_out_b_reg
                                                                 : port_value_reg[1];
  assign wave_pin_a_o.pin_oe_n = !wave_pin_direction_reg[0];
  assign wave_pin_b_o.pin_oe_n = !wave_pin_direction_reg[1];
  assign wave_out_a_o = wave_out_a_reg;
  assign wave_out_b_o = wave_out_b_reg;

endmodule : timer8_compare_output_unit

// >>> verification/timer8_compare_output_unit_assertions.sv
// Port-level assertions for the timer compare unit.
`timescale 1ns/1ps
module timer8_checker
  import timer8_pkg::*;
(
  input wire logic clock_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic psel_i, // Select
  input wire logic penable_i, // Enable
  input wire logic pwrite_i, // Direction
  input wire logic [7:0] paddr_i, // Address
  input wire logic [31:0] prdata_o, // Read data
  input wire logic pslverr_o, // Error
  input wire logic prescale_tick_i, // Tick
  input wire logic irq_ack_wrap_i, // Wrap serviced
  input wire logic irq_ack_a_i, // A serviced
  input wire logic irq_wrap_o, // Wrap request
  input wire logic irq_match_a_o, // A request
  input wire logic wave_out_a_o, // State A
  input wire logic wave_out_b_o // State B
);
  // ==========
  // Decodes
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire logic acc = psel_i && penable_i;
  wire logic wr = acc && pwrite_i;
  wire logic ctl_wr = wr && paddr_i == ADDR_CTRL;
  wire logic mapped = paddr_i[1:0] == 2'h0 && paddr_i <= ADDR_PORT;
  // ==========
  // Properties
  property p_state_a;
    $changed(wave_out_a_o) |-> $past(prescale_tick_i || ctl_wr);
  endproperty
  a_state_a: assert property (p_state_a)
    else $error("state A changed without tick or force");
  property p_state_b;
    $changed(wave_out_b_o) |-> $past(prescale_tick_i || ctl_wr);
  endproperty
  a_state_b: assert property (p_state_b)
    else $error("state B changed without tick or force");
  property p_irq_a_rise;
    $rose(irq_match_a_o) |-> $past(prescale_tick_i || wr);
  endproperty
  a_irq_a_rise: assert property (p_irq_a_rise)
    else $error("A request rose without tick");
  property p_irq_a_fall;
    $fell(irq_match_a_o) |-> $past(irq_ack_a_i || wr);
  endproperty
  a_irq_a_fall: assert property (p_irq_a_fall)
    else $error("A request fell without service");
  property p_wrap_rise;
    $rose(irq_wrap_o) |-> $past(prescale_tick_i || wr);
  endproperty
  a_wrap_rise: assert property (p_wrap_rise)
    else $error("wrap request rose without tick");
  property p_wrap_fall;
    $fell(irq_wrap_o) |-> $past(irq_ack_wrap_i || wr);
  endproperty
  a_wrap_fall: assert property (p_wrap_fall)
    else $error("wrap request fell without service");
  property p_reset_clear;
    $fell(rst_i) |-> !wave_out_a_o && !wave_out_b_o && !irq_wrap_o && !irq_match_a_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");
  property p_refuse;
    acc && !mapped |-> pslverr_o && prdata_o == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("unmapped access not refused");
  property p_accept;
    psel_i && !penable_i ##1 acc && mapped |-> !pslverr_o;
  endproperty
  a_accept: assert property (p_accept)
    else $error("mapped access refused");
  c_force: cover property (ctl_wr ##1 $changed(wave_out_a_o));
  c_irq_a: cover property ($rose(irq_match_a_o));
  c_refuse: cover property (acc && !mapped);
endmodule : timer8_checker

bind timer8_compare_output_unit timer8_checker u_timer8_checker (
  .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .prescale_tick_i(prescale_tick_i), .irq_ack_wrap_i(irq_ack_wrap_i),
  .irq_ack_a_i(irq_ack_a_i), .irq_wrap_o(irq_wrap_o), .irq_match_a_o(irq_match_a_o),
  .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o)
);

// >>> verification/timer8_compare_output_unit_tb_top.sv
// Self-checking bench for the timer compare unit with a cycle model.
`timescale 1ns/1ps
module timer8_compare_output_unit_tb_top
  import timer8_pkg::*;
;
  logic clock_i, rst_i, psel_i, penable_i, pwrite_i, prescale_tick_i, pready_o, pslverr_o;
  logic irq_ack_wrap_i, irq_ack_a_i, irq_ack_b_i, irq_wrap_o, irq_match_a_o, irq_match_b_o;
  logic wave_out_a_o, wave_out_b_o, tick_on, m_oa, m_ob, m_blk, m_pa, m_pb, m_ha, m_hb;
  logic m_tk, m_np, m_wr, m_cw, m_fa, m_fb;
  logic [7:0] paddr_i, m_cnt, m_ma, m_mb;
  logic [31:0] pwdata_i, prdata_o;
  logic [2:0] m_mode, m_src, m_fl, m_en, m_clr;
  logic [1:0] m_aa, m_ab;
  logic [3:0] m_port;
  pin_drive_t wave_pin_a_o, wave_pin_b_o;
  int error_cnt = 0;
  int comparisons = 0;
  integer seed = 4568;

  timer8_compare_output_unit u_timer8_compare_output_unit (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .prescale_tick_i(prescale_tick_i),
    .irq_ack_wrap_i(irq_ack_wrap_i), .irq_ack_a_i(irq_ack_a_i), .irq_ack_b_i(irq_ack_b_i),
    .irq_wrap_o(irq_wrap_o), .irq_match_a_o(irq_match_a_o), .irq_match_b_o(irq_match_b_o),
    .wave_pin_a_o(wave_pin_a_o), .wave_pin_b_o(wave_pin_b_o),
    .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o)
  );

  always #5 clock_i = ~clock_i;

  // ==========
  // Helpers
  function automatic logic act(input logic s, input logic [1:0] c);
    return (c == ACT_NONE) ? s : (c == ACT_TOGGLE) ? !s : (c == ACT_SET);
  endfunction : act

  function automatic logic [31:0] cw(input logic [2:0] m, s, input logic [1:0] a, b, f);
    return {20'h0, f, b, a, s, m};
  endfunction : cw

  function automatic logic [31:0] rdv(input logic [7:0] a);
    case (a)
      ADDR_COUNT: return {24'h0, m_cnt};
      ADDR_MATCH_A: return {24'h0, m_ma};
      ADDR_MATCH_B: return {24'h0, m_mb};
      ADDR_CTRL: return {22'h0, m_ab, m_aa, m_src, m_mode};
      ADDR_FLAGS: return {29'h0, m_fl};
      ADDR_IRQ_EN: return {29'h0, m_en};
      ADDR_PORT: return {28'h0, m_port};
      default: return 32'h0;
    endcase
  endfunction : rdv

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
  endtask : apb

  task automatic run(input int n);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask : run

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // ==========
  // Random ticks and services; ticks may meet bus writes, so write priority is exercised.
  always @(posedge clock_i) begin
    prescale_tick_i <= tick_on && ($random(seed) & 3) == 0;
    {irq_ack_b_i, irq_ack_a_i, irq_ack_wrap_i} <= (($random(seed) & 31) == 0) ? 3'($random(seed)) : 3'h0;
  end

  // ==========
  // Cycle model; irq, state and pin outputs compared at every edge out of reset, bus outputs during access.
  always @(posedge clock_i) begin
    if (rst_i) begin
      {m_cnt, m_ma, m_mb, m_mode, m_src, m_fl, m_en, m_aa, m_ab, m_port} = '0;
      {m_oa, m_ob, m_blk, m_pa, m_pb} = '0;
    end else begin
      chk({irq_match_b_o, irq_match_a_o, irq_wrap_o}, m_fl & m_en);
      chk({wave_out_b_o, wave_out_a_o}, {m_ob, m_oa});
      chk({wave_pin_b_o, wave_pin_a_o}, {(m_ab != 0) ? m_ob : m_port[1], !m_port[3], (m_aa != 0) ? m_oa : m_port[0], !m_port[2]});
      m_wr = psel_i && penable_i && pwrite_i;
      m_cw = m_wr && paddr_i == ADDR_COUNT;
      m_fa = m_wr && paddr_i == ADDR_CTRL && pwdata_i[10];
      m_fb = m_wr && paddr_i == ADDR_CTRL && pwdata_i[11];
      if (psel_i && penable_i) chk(pready_o, 1'b1);
      if (psel_i && penable_i) chk(pslverr_o, !(paddr_i[1:0] == 0 && paddr_i <= ADDR_PORT));
      if (psel_i && penable_i && !pwrite_i) chk(prdata_o, rdv(paddr_i));
      m_tk = prescale_tick_i && m_src != 0;
      m_np = m_mode == WAVE_NORMAL || m_mode == WAVE_CLEAR_ON_MATCH;
      m_ha = m_tk && m_cnt == m_ma && !m_blk;
      m_hb = m_tk && m_cnt == m_mb && !m_blk;
      m_clr = {irq_ack_b_i, irq_ack_a_i, irq_ack_wrap_i};
      if (m_wr && paddr_i == ADDR_FLAGS) m_clr = m_clr | pwdata_i[2:0];
      m_fl = (m_fl & ~m_clr) | {m_tk & m_pb, m_tk & m_pa, m_tk & !m_cw & m_cnt == COUNT_MAX};
      if ((m_ha || m_fa) && m_np) m_oa = act(m_oa, m_aa);
      if ((m_hb || m_fb) && m_np) m_ob = act(m_ob, m_ab);
      if (m_tk) begin
        m_pa = m_ha;
        m_pb = m_hb;
        m_blk = 1'b0;
        m_cnt = (m_mode == WAVE_CLEAR_ON_MATCH && m_ha) ? 8'h0 : m_cnt + 8'h1;
      end
      if (m_wr && paddr_i == ADDR_COUNT) m_blk = 1'b1;
      if (m_wr) begin
        case (paddr_i)
          ADDR_COUNT: m_cnt = pwdata_i[7:0];
          ADDR_MATCH_A: m_ma = pwdata_i[7:0];
          ADDR_MATCH_B: m_mb = pwdata_i[7:0];
          ADDR_CTRL: {m_ab, m_aa, m_src, m_mode} = pwdata_i[9:0];
          ADDR_IRQ_EN: m_en = pwdata_i[2:0];
          ADDR_PORT: m_port = pwdata_i[3:0];
          default: ;
        endcase
      end
    end
  end

  initial begin
    #300000;
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    conclude();
  end

  // ==========
  // Scenarios
  initial begin
    {clock_i, rst_i, psel_i, penable_i, pwrite_i, tick_on} = 6'b010000;
    {paddr_i, pwdata_i, prescale_tick_i, irq_ack_wrap_i, irq_ack_a_i, irq_ack_b_i} = '0;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    for (int i = 0; i < 9; i++) apb(1'b0, 8'(i * 4), 32'h0);
    apb(1'b1, 8'h1c, 32'hffffffff);
    apb(1'b0, 8'h1c, 32'h0);
    run(2);
    $display("test reset_and_map done");
    apb(1'b1, ADDR_IRQ_EN, 32'h7);
    apb(1'b1, ADDR_MATCH_A, 32'h10);
    apb(1'b1, ADDR_MATCH_B, {24'h0, 8'($random(seed))});
    apb(1'b1, ADDR_CTRL, cw(WAVE_NORMAL, 3'h1, ACT_TOGGLE, ACT_SET, 2'h0));
    tick_on <= 1'b1;
    run(2300);
    apb(1'b1, ADDR_FLAGS, 32'h7);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    $display("test normal_count done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ADDR_CTRL, cw(WAVE_NORMAL, 3'h1, 2'(i), 2'(3 - i), 2'h3));
      apb(1'b0, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_PORT, (i > 3 ? 32'hc : 32'h0) | (32'($random(seed)) & 32'h3));
      run(150);
    end
    $display("test force_and_pins done");
    apb(1'b1, ADDR_CTRL, cw(WAVE_NORMAL, 3'h0, ACT_TOGGLE, ACT_TOGGLE, 2'h0));
    apb(1'b1, ADDR_COUNT, 32'h10);
    run(60);
    apb(1'b0, ADDR_COUNT, 32'h0);
    apb(1'b1, ADDR_CTRL, cw(WAVE_NORMAL, 3'h1, ACT_TOGGLE, ACT_TOGGLE, 2'h0));
    run(40);
    for (int i = 0; i < 4; i++) apb(1'b1, ADDR_COUNT, 32'h10);
    run(200);
    $display("test count_write done");
    apb(1'b1, ADDR_MATCH_A, 32'h5);
    apb(1'b1, ADDR_CTRL, cw(WAVE_CLEAR_ON_MATCH, 3'h1, ACT_TOGGLE, ACT_CLEAR, 2'h0));
    run(1300);
    apb(1'b1, ADDR_MATCH_A, 32'h40);
    run(120);
    apb(1'b1, ADDR_MATCH_A, 32'h3);
    run(1300);
    $display("test clear_on_match done");
    apb(1'b1, ADDR_CTRL, cw(WAVE_FAST_PWM, 3'h0, ACT_TOGGLE, ACT_TOGGLE, 2'h0));
    apb(1'b1, ADDR_CTRL, cw(WAVE_FAST_PWM, 3'h0, ACT_TOGGLE, ACT_TOGGLE, 2'h3));
    apb(1'b1, ADDR_CTRL, cw(WAVE_NORMAL, 3'h0, ACT_SET, ACT_NONE, 2'h0));
    run(10);
    $display("test mode_change done");
    conclude();
  end
endmodule : timer8_compare_output_unit_tb_top
